// file: lcdid_pkg.sv
package lcdid_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_REF_KHZ = 270;
  localparam longint T_CLEAR_NS = 1520000;
  localparam longint T_SHORT_NS = 37000;
  localparam longint T_LONG_NS = 56000;
  localparam longint T_RESET_BUSY_NS = 10000000;
  localparam int CNT_W = 17;
  typedef logic [CNT_W-1:0] lcdid_cnt_t;

  ////////////////////////////////////////////////////////////////////////////
  // Memories
  localparam int DATA_W = 8;
  localparam int TEXT_AW = 7;
  localparam int TEXT_DEPTH = 128;
  localparam int GLYPH_AW = 5;
  localparam int GLYPH_DEPTH = 32;
  localparam int GLYPH_DW = 5;
  localparam logic [7:0] SPACE_CODE = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside command and status bytes
  localparam int ENTRY_DIR_BIT = 1;
  localparam int ENTRY_SHIFT_BIT = 0;
  localparam int DISP_ON_BIT = 2;
  localparam int DISP_CURSOR_BIT = 1;
  localparam int DISP_BLINK_BIT = 0;
  localparam int SHIFT_SC_BIT = 3;
  localparam int SHIFT_RL_BIT = 2;
  localparam int FUNC_WIDTH_BIT = 4;
  localparam int FUNC_ADDR_BIT = 3;
  localparam int FUNC_LAYOUT_BIT = 1;
  localparam int FUNC_PAD_BIT = 0;
  localparam int BUSY_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic RST_BUS_WIDTH = 1'b1;
  localparam logic RST_ADDR_MODE = 1'b0;
  localparam logic RST_LAYOUT = 1'b0;
  localparam logic RST_PAD_ORDER = 1'b0;
  localparam logic RST_DISPLAY = 1'b0;
  localparam logic RST_CURSOR = 1'b0;
  localparam logic RST_BLINK = 1'b0;
  localparam logic RST_STEP_DIR = 1'b1;
  localparam logic RST_AUTO_SHIFT = 1'b0;

  typedef enum logic [8:0] {
    CMD_NOP = 9'h001,
    CMD_CLEAR = 9'h002,
    CMD_HOME = 9'h004,
    CMD_ENTRY = 9'h008,
    CMD_DISPCTL = 9'h010,
    CMD_SHIFT = 9'h020,
    CMD_FUNC = 9'h040,
    CMD_GLYPH_ADDR = 9'h080,
    CMD_TEXT_ADDR = 9'h100
  } lcdid_cmd_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'h1,
    ST_SWEEP = 2'h2
  } lcdid_state_e;

  // Least time, scaled by oscillator rate, rounded up to whole clocks
  function automatic int cycles(longint ns, int osc_khz);
    longint den;
    longint c;
    den = longint'(osc_khz) * CLK_PERIOD_NS;
    c = (ns * OSC_REF_KHZ + den - 1) / den;
    if (c < 1) c = 1;
    return int'(c);
  endfunction : cycles

  // Class is given by the highest set bit of the byte
  function automatic lcdid_cmd_e decode(logic [7:0] b);
    if (b[7]) return CMD_TEXT_ADDR;
    else if (b[6]) return CMD_GLYPH_ADDR;
    else if (b[5]) return CMD_FUNC;
    else if (b[4]) return CMD_SHIFT;
    else if (b[3]) return CMD_DISPCTL;
    else if (b[2]) return CMD_ENTRY;
    else if (b[1]) return CMD_HOME;
    else if (b[0]) return CMD_CLEAR;
    else return CMD_NOP;
  endfunction : decode

endpackage : lcdid_pkg

// file: lcdid_exec_if.sv
`timescale 1ns/1ps
interface lcdid_exec_if;
  logic start;
  lcdid_pkg::lcdid_cnt_t cycles;
  logic busy;
  modport ctrl (output start, output cycles, input busy);
  modport timer (input start, input cycles, output busy);
endinterface : lcdid_exec_if

// file: lcdid_exec_timer.sv
`timescale 1ns/1ps
module lcdid_exec_timer #(
  parameter lcdid_pkg::lcdid_cnt_t RESET_CYCLES = lcdid_pkg::lcdid_cnt_t'(
    lcdid_pkg::cycles(lcdid_pkg::T_RESET_BUSY_NS, lcdid_pkg::OSC_REF_KHZ))
) (
  input logic mclk,
  input logic rstn,
  lcdid_exec_if.timer ex
);

  lcdid_pkg::lcdid_cnt_t remain;

  // Counter width limits the slowest oscillator setting that still fits
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      remain <= RESET_CYCLES;
    end else if (ex.start) begin
      remain <= ex.cycles;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  assign ex.busy = (remain != '0);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  busy_hold_a: assert property (
    ex.start |=> ex.busy [*8])
    else $error("busy dropped too early after start");

  reset_busy_a: assert property (
    !$past(rstn) |-> ex.busy && remain == RESET_CYCLES)
    else $error("busy not held after reset release");

endmodule : lcdid_exec_timer

// file: lcdid_decoder.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module lcdid_decoder #(
  parameter int OSC_KHZ = lcdid_pkg::OSC_REF_KHZ,
  parameter lcdid_pkg::lcdid_cnt_t CLEAR_CYCLES = lcdid_pkg::lcdid_cnt_t'(
    lcdid_pkg::cycles(lcdid_pkg::T_CLEAR_NS, OSC_KHZ)),
  parameter lcdid_pkg::lcdid_cnt_t RESET_CYCLES = lcdid_pkg::lcdid_cnt_t'(
    lcdid_pkg::cycles(lcdid_pkg::T_RESET_BUSY_NS, lcdid_pkg::OSC_REF_KHZ))
) (
  input logic mclk,
  input logic rstn,
  input logic register_select,
  input logic read_write,
  input logic enable_strobe,
  input logic [7:0] parallel_data_lines_in,
  output logic [7:0] parallel_data_lines_out,
  output logic parallel_data_lines_oe,
  input logic [6:0] disp_addr,
  output logic [7:0] disp_char,
  input logic [4:0] glyph_addr,
  output logic [4:0] glyph_row,
  output logic display_enable,
  output logic cursor_visible,
  output logic char_blink,
  output logic step_direction,
  output logic auto_shift,
  output logic [6:0] display_shift,
  output logic [6:0] address_counter,
  output logic glyph_selected,
  output logic bus_width_select,
  output logic addressing_mode_select,
  output logic layout_select,
  output logic pad_order_select,
  output logic busy_indicator
);

  localparam lcdid_pkg::lcdid_cnt_t SHORT_CYC = lcdid_pkg::lcdid_cnt_t'(
    lcdid_pkg::cycles(lcdid_pkg::T_SHORT_NS, OSC_KHZ));
  localparam lcdid_pkg::lcdid_cnt_t LONG_CYC = lcdid_pkg::lcdid_cnt_t'(
    lcdid_pkg::cycles(lcdid_pkg::T_LONG_NS, OSC_KHZ));
  localparam int PIN_W = 11;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and strobe edges
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic s_sel;
  logic s_rd;
  logic s_en;
  logic [7:0] s_data;
  logic en_d;
  logic cap_sel;
  logic cap_rd;
  logic [7:0] cap_data;
  logic en_rise;
  logic en_fall;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {register_select, read_write, enable_strobe,
                   parallel_data_lines_in};
      pin_sync <= pin_meta;
    end
  end

  assign {s_sel, s_rd, s_en, s_data} = pin_sync;
  assign en_rise = s_en & ~en_d;
  assign en_fall = ~s_en & en_d;

  // Capture while strobe is high so the data hold after the fall is moot
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      en_d <= 1'b0;
      cap_sel <= 1'b0;
      cap_rd <= 1'b0;
      cap_data <= 8'h00;
    end else begin
      en_d <= s_en;
      if (s_en) begin
        cap_sel <= s_sel;
        cap_rd <= s_rd;
        cap_data <= s_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nibble pairing
  logic nib_low;
  logic [3:0] nib_hi;
  logic last_part;
  logic take_wr;
  logic take_rd;
  logic [7:0] wr_byte;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      nib_low <= 1'b0;
      nib_hi <= 4'h0;
    end else if (bus_width_select) begin
      nib_low <= 1'b0;
    end else if (en_fall) begin
      if (!nib_low && !cap_rd) begin
        nib_hi <= cap_data[7:4];
      end
      nib_low <= ~nib_low;
    end
  end

  assign last_part = bus_width_select | nib_low;
  assign take_wr = en_fall & ~cap_rd & last_part;
  assign take_rd = en_fall & cap_rd & last_part;
  assign wr_byte = bus_width_select ? cap_data : {nib_hi, cap_data[7:4]};

  ////////////////////////////////////////////////////////////////////////////
  // Decode; commands and data transfers while busy are dropped
  lcdid_pkg::lcdid_cmd_e cmd;
  lcdid_pkg::lcdid_state_e state;
  logic cmd_go;
  logic dat_wr;
  logic dat_rd;
  logic [6:0] ac_inc;
  logic [6:0] ac_dec;
  logic [6:0] sweep_idx;
  lcdid_exec_if ex_if ();

  assign cmd = lcdid_pkg::decode(wr_byte);
  assign cmd_go = take_wr & ~cap_sel & ~busy_indicator;
  assign dat_wr = take_wr & cap_sel & ~busy_indicator;
  assign dat_rd = take_rd & cap_sel & ~busy_indicator;
  assign busy_indicator = ex_if.busy | (state == lcdid_pkg::ST_SWEEP);

  // Glyph pointer wraps within its own range
  assign ac_inc = glyph_selected ?
    {2'h0, address_counter[4:0] + 5'h01} : address_counter + 7'h01;
  assign ac_dec = glyph_selected ?
    {2'h0, address_counter[4:0] - 5'h01} : address_counter - 7'h01;

  // A zero byte starts nothing, so it changes no state
  assign ex_if.start = (cmd_go & (cmd != lcdid_pkg::CMD_NOP))
                       | dat_wr | dat_rd;

  always_comb begin
    ex_if.cycles = SHORT_CYC;
    if (cmd_go && cmd == lcdid_pkg::CMD_CLEAR) begin
      ex_if.cycles = CLEAR_CYCLES;
    end else if ((cmd_go && cmd == lcdid_pkg::CMD_SHIFT) || dat_rd) begin
      ex_if.cycles = LONG_CYC;
    end
  end

  lcdid_exec_timer #(
    .RESET_CYCLES(RESET_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .ex(ex_if.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      step_direction <= lcdid_pkg::RST_STEP_DIR;
      auto_shift <= lcdid_pkg::RST_AUTO_SHIFT;
      display_enable <= lcdid_pkg::RST_DISPLAY;
      cursor_visible <= lcdid_pkg::RST_CURSOR;
      char_blink <= lcdid_pkg::RST_BLINK;
      bus_width_select <= lcdid_pkg::RST_BUS_WIDTH;
      addressing_mode_select <= lcdid_pkg::RST_ADDR_MODE;
      layout_select <= lcdid_pkg::RST_LAYOUT;
      pad_order_select <= lcdid_pkg::RST_PAD_ORDER;
    end else if (cmd_go) begin
      case (cmd)
        lcdid_pkg::CMD_CLEAR: begin
          step_direction <= 1'b1;
        end
        lcdid_pkg::CMD_ENTRY: begin
          step_direction <= wr_byte[lcdid_pkg::ENTRY_DIR_BIT];
          auto_shift <= wr_byte[lcdid_pkg::ENTRY_SHIFT_BIT];
        end
        lcdid_pkg::CMD_DISPCTL: begin
          display_enable <= wr_byte[lcdid_pkg::DISP_ON_BIT];
          cursor_visible <= wr_byte[lcdid_pkg::DISP_CURSOR_BIT];
          char_blink <= wr_byte[lcdid_pkg::DISP_BLINK_BIT];
        end
        lcdid_pkg::CMD_FUNC: begin
          bus_width_select <= wr_byte[lcdid_pkg::FUNC_WIDTH_BIT];
          addressing_mode_select <= wr_byte[lcdid_pkg::FUNC_ADDR_BIT];
          layout_select <= wr_byte[lcdid_pkg::FUNC_LAYOUT_BIT];
          pad_order_select <= wr_byte[lcdid_pkg::FUNC_PAD_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address counter, RAM target and display shift
  // Shift count rises when the picture moves left
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      address_counter <= 7'h00;
      glyph_selected <= 1'b0;
      display_shift <= 7'h00;
    end else if (cmd_go) begin
      case (cmd)
        lcdid_pkg::CMD_CLEAR, lcdid_pkg::CMD_HOME: begin
          address_counter <= 7'h00;
          glyph_selected <= 1'b0;
          display_shift <= 7'h00;
        end
        lcdid_pkg::CMD_SHIFT: begin
          if (wr_byte[lcdid_pkg::SHIFT_SC_BIT]) begin
            display_shift <= wr_byte[lcdid_pkg::SHIFT_RL_BIT] ?
              display_shift - 7'h01 : display_shift + 7'h01;
          end else begin
            address_counter <= wr_byte[lcdid_pkg::SHIFT_RL_BIT] ?
              ac_inc : ac_dec;
          end
        end
        lcdid_pkg::CMD_GLYPH_ADDR: begin
          address_counter <= {2'h0, wr_byte[4:0]};
          glyph_selected <= 1'b1;
        end
        lcdid_pkg::CMD_TEXT_ADDR: begin
          address_counter <= wr_byte[6:0];
          glyph_selected <= 1'b0;
        end
        default: begin
        end
      endcase
    end else if (dat_wr || dat_rd) begin
      address_counter <= step_direction ? ac_inc : ac_dec;
      if (dat_wr && !glyph_selected && auto_shift) begin
        display_shift <= step_direction ?
          display_shift + 7'h01 : display_shift - 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear sweep; reset runs one too so text RAM starts blank
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= lcdid_pkg::ST_SWEEP;
      sweep_idx <= 7'h00;
    end else begin
      case (state)
        lcdid_pkg::ST_RUN: begin
          if (cmd_go && cmd == lcdid_pkg::CMD_CLEAR) begin
            state <= lcdid_pkg::ST_SWEEP;
            sweep_idx <= 7'h00;
          end
        end
        lcdid_pkg::ST_SWEEP: begin
          sweep_idx <= sweep_idx + 7'h01;
          if (&sweep_idx) begin
            state <= lcdid_pkg::ST_RUN;
          end
        end
        default: begin
          state <= lcdid_pkg::ST_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memories
  logic [7:0] text_mem [lcdid_pkg::TEXT_DEPTH];
  logic [lcdid_pkg::GLYPH_DW-1:0] glyph_mem [lcdid_pkg::GLYPH_DEPTH];
  logic [7:0] rd_byte;

  always_ff @(posedge mclk) begin
    if (state == lcdid_pkg::ST_SWEEP) begin
      text_mem[sweep_idx] <= lcdid_pkg::SPACE_CODE;
    end else if (dat_wr && !glyph_selected) begin
      text_mem[address_counter] <= wr_byte;
    end
  end

  always_ff @(posedge mclk) begin
    if (dat_wr && glyph_selected) begin
      glyph_mem[address_counter[4:0]] <=
        wr_byte[lcdid_pkg::GLYPH_DW-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      disp_char <= 8'h00;
      glyph_row <= 5'h00;
    end else begin
      disp_char <= text_mem[disp_addr];
      glyph_row <= glyph_mem[glyph_addr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; data is latched on the strobe rise
  always_comb begin
    rd_byte = {busy_indicator, address_counter};
    if (s_sel) begin
      rd_byte = glyph_selected ?
        {{(8-lcdid_pkg::GLYPH_DW){1'b0}}, glyph_mem[address_counter[4:0]]}
        : text_mem[address_counter];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      parallel_data_lines_out <= 8'h00;
      parallel_data_lines_oe <= 1'b0;
    end else begin
      parallel_data_lines_oe <= s_en & s_rd;
      if (en_rise && s_rd) begin
        if (bus_width_select) begin
          parallel_data_lines_out <= rd_byte;
        end else begin
          parallel_data_lines_out <= nib_low ?
            {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_cmd(lcdid_pkg::lcdid_cmd_e c);
    cmd_go && cmd == c;
  endsequence

  clear_cmd_a: assert property (
    s_cmd(lcdid_pkg::CMD_CLEAR) |=> address_counter == 7'h00
      && step_direction && auto_shift == $past(auto_shift)
      && state == lcdid_pkg::ST_SWEEP)
    else $error("clear did not reset address or direction");

  clear_sweep_a: assert property (
    s_cmd(lcdid_pkg::CMD_CLEAR) |-> ##[1:130] state == lcdid_pkg::ST_RUN)
    else $error("clear sweep did not finish");

  home_a: assert property (
    s_cmd(lcdid_pkg::CMD_HOME) |=> address_counter == 7'h00
      && display_shift == 7'h00 && busy_indicator)
    else $error("home did not reset address and shift");

  entry_mode_a: assert property (
    s_cmd(lcdid_pkg::CMD_ENTRY) |=>
      step_direction == $past(wr_byte[1]) && auto_shift == $past(wr_byte[0]))
    else $error("entry mode fields not stored");

  disp_ctl_a: assert property (
    s_cmd(lcdid_pkg::CMD_DISPCTL) |=> display_enable == $past(wr_byte[2])
      && cursor_visible == $past(wr_byte[1])
      && char_blink == $past(wr_byte[0]))
    else $error("display control fields not stored");

  func_set_a: assert property (
    s_cmd(lcdid_pkg::CMD_FUNC) |=> bus_width_select == $past(wr_byte[4])
      && addressing_mode_select == $past(wr_byte[3])
      && layout_select == $past(wr_byte[1])
      && pad_order_select == $past(wr_byte[0]))
    else $error("function set fields not stored");

  shift_time_a: assert property (
    s_cmd(lcdid_pkg::CMD_SHIFT) |-> ex_if.start && ex_if.cycles == LONG_CYC)
    else $error("shift not timed with the long execution time");

  nop_a: assert property (
    cmd_go && cmd == lcdid_pkg::CMD_NOP && bus_width_select |=>
      $stable(address_counter) && $stable(display_shift) && !busy_indicator)
    else $error("zero byte changed state");

  text_write_a: assert property (
    dat_wr && !glyph_selected |=>
      text_mem[$past(address_counter)] == $past(wr_byte) && busy_indicator)
    else $error("data write did not reach text RAM");

  no_shift_a: assert property (
    dat_rd || (dat_wr && glyph_selected) |=> $stable(display_shift))
    else $error("display shifted on a read or glyph access");

  status_read_a: assert property (
    en_rise && s_rd && !s_sel && bus_width_select |=>
      parallel_data_lines_out == {$past(busy_indicator),
                                  $past(address_counter)})
    else $error("status read returned wrong byte");

  nibble_pair_a: assert property (
    !bus_width_select && en_fall && !cap_rd && !nib_low |=>
      nib_low && nib_hi == $past(cap_data[7:4]) && !ex_if.busy[*1])
    else $error("upper nibble not held for pairing");

endmodule : lcdid_decoder

// file: lcdid_host_model.sv
`timescale 1ns/1ps
module lcdid_host_model (
  input wire logic mclk,
  output logic register_select,
  output logic read_write,
  output logic enable_strobe,
  output logic [7:0] bus_in,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe
);
  logic [7:0] drv = 8'h00;
  initial begin
    register_select = 1'b0;
    read_write = 1'b0;
    enable_strobe = 1'b0;
  end
  // Released lines show the inverse of the last value, never a held one
  assign bus_in = bus_oe ? bus_out : drv;
  //////////////////////////////////////////////////////////////////////////////
  // Lines are held from setup until the strobe has been low for 6 clocks
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge mclk);
    register_select <= rs;
    read_write <= rw;
    drv <= rw ? ~drv : d;
    @(posedge mclk);
    enable_strobe <= 1'b1;
    repeat (6) @(posedge mclk);
    q = bus_in;
    enable_strobe <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : xfer
  task automatic put(input logic rs, input logic rw, input logic [7:0] d,
                     input logic four, output logic [7:0] q);
    logic [7:0] hi;
    // A zero command in narrow width is skipped and never sent to the decoder
    if (four && !rs && !rw && d == 8'h00) return;
    if (!four) xfer(rs, rw, d, q);
    else begin
      xfer(rs, rw, {d[7:4], 4'h0}, hi);
      xfer(rs, rw, {d[3:0], 4'h0}, q);
      q = {hi[7:4], q[7:4]};
    end
  endtask : put
endmodule : lcdid_host_model

// file: tb_lcd_instruction_decoder.sv
`timescale 1ns/1ps
module tb_lcd_instruction_decoder;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic four = 1'b0;
  logic rs, rw, en, oe, busy, den, cur, blk, sdir, ash, gsel, bw, am, lay, pad;
  logic [7:0] din, dout, dchar, q;
  logic [6:0] disp_addr = 7'h00;
  logic [6:0] dsh, ac;
  logic [4:0] glyph_addr = 5'h00;
  logic [4:0] grow;
  int miscompares = 0;
  int tests_run = 0;
  int run = 0;
  int busy_len = 0;
  always #50 mclk = ~mclk;
  lcdid_host_model host (.mclk(mclk), .register_select(rs), .read_write(rw),
    .enable_strobe(en), .bus_in(din), .bus_out(dout), .bus_oe(oe));
  // Clear time kept above the 128-cycle sweep so the timer sets the length
  lcdid_decoder #(.CLEAR_CYCLES(17'h96), .RESET_CYCLES(17'hC8)) dut (
    .mclk(mclk), .rstn(rstn), .register_select(rs), .read_write(rw),
    .enable_strobe(en), .parallel_data_lines_in(din),
    .parallel_data_lines_out(dout), .parallel_data_lines_oe(oe),
    .disp_addr(disp_addr), .disp_char(dchar), .glyph_addr(glyph_addr),
    .glyph_row(grow), .display_enable(den), .cursor_visible(cur),
    .char_blink(blk), .step_direction(sdir), .auto_shift(ash),
    .display_shift(dsh), .address_counter(ac), .glyph_selected(gsel),
    .bus_width_select(bw), .addressing_mode_select(am),
    .layout_select(lay), .pad_order_select(pad), .busy_indicator(busy));
  // Length of the last busy run, in clocks
  always @(posedge mclk) begin
    run <= (busy === 1'b1 && rstn) ? run + 1 : 0;
    if (busy !== 1'b1 && run != 0) busy_len <= run;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(string n, logic [16:0] e, logic [16:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 20000) begin
        miscompares++;
        wrap_up;
      end
    end
    repeat (2) @(posedge mclk);
    #1;
  endtask : wait_idle
  task automatic cmd(logic [7:0] c);
    host.put(1'b0, 1'b0, c, four, q);
    wait_idle;
  endtask : cmd
  task automatic acc(logic r, logic [7:0] d);
    host.put(1'b1, r, d, four, q);
    wait_idle;
  endtask : acc
  task automatic ram(logic [6:0] a, logic [7:0] e);
    @(posedge mclk);
    disp_addr <= a;
    repeat (2) @(posedge mclk);
    #1;
    chk("text_ram", e, dchar);
  endtask : ram
  //////////////////////////////////////////////////////////////////////////////
  task automatic s_write;
    cmd(8'h85);
    chk("ac", 7'h05, ac);
    chk("len", 370, busy_len);
    host.put(1'b1, 1'b0, 8'h41, four, q);
    host.put(1'b0, 1'b1, 8'h00, four, q);
    chk("stat_busy", 8'h86, q);
    wait_idle;
    chk("len", 370, busy_len);
    ram(7'h05, 8'h41);
    host.put(1'b0, 1'b1, 8'h00, four, q);
    chk("stat", 8'h06, q);
    cmd(8'h85);
    acc(1'b1, 8'h00);
    chk("rd", 8'h41, q);
    chk("len", 560, busy_len);
    chk("ac", 7'h06, ac);
  endtask : s_write
  task automatic s_entry;
    cmd(8'h05);
    chk("mode", 2'b01, {sdir, ash});
    acc(1'b0, 8'h42);
    chk("shift_ac", {7'h7F, 7'h05}, {dsh, ac});
    acc(1'b1, 8'h00);
    chk("rd_no_shift", {7'h7F, 7'h04}, {dsh, ac});
  endtask : s_entry
  task automatic s_disp;
    for (int i = 0; i < 2; i++) begin
      cmd(i ? 8'h0A : 8'h0D);
      chk("disp", i ? 3'h2 : 3'h5, {den, cur, blk});
    end
  endtask : s_disp
  task automatic s_shift;
    logic [7:0] c [4] = '{8'h18, 8'h14, 8'h1C, 8'h10};
    logic [13:0] e [4] = '{14'h0004, 14'h0005, 14'h3F85, 14'h3F84};
    for (int i = 0; i < 4; i++) begin
      cmd(c[i]);
      chk("shift", e[i], {dsh, ac});
      chk("len", 560, busy_len);
    end
    cmd(8'h03);
    chk("home", 14'h0000, {dsh, ac});
    chk("len", 370, busy_len);
    ram(7'h05, 8'h41);
  endtask : s_shift
  task automatic s_glyph;
    cmd(8'h63);
    chk("gsel_ac", 8'h83, {gsel, ac});
    acc(1'b0, 8'h1F);
    chk("g_no_shift", 14'h0002, {dsh, ac});
    @(posedge mclk);
    glyph_addr <= 5'h03;
    repeat (2) @(posedge mclk);
    #1;
    chk("glyph_row", 5'h1F, grow);
    cmd(8'h63);
    acc(1'b1, 8'h00);
    chk("g_rd", 8'h1F, q);
    host.put(1'b0, 1'b0, 8'h00, four, q);
    chk("nop", {1'b0, 7'h02}, {busy, ac});
  endtask : s_glyph
  task automatic s_clear;
    cmd(8'h01);
    chk("len", 150, busy_len);
    chk("clr", {3'h6, 7'h00}, {sdir, ash, gsel, ac});
    ram(7'h05, 8'h20);
  endtask : s_clear
  task automatic s_func;
    cmd(8'h2B);
    chk("func", 4'h7, {bw, am, lay, pad});
    four = 1'b1;
    cmd(8'h86);
    chk("nib_ac", 7'h06, ac);
    host.put(1'b0, 1'b1, 8'h00, four, q);
    chk("nib_stat", 8'h06, q);
    cmd(8'h30);
    chk("func8", 4'h8, {bw, am, lay, pad});
    four = 1'b0;
  endtask : s_func
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    chk("rst", 3'h7, {sdir, bw, busy});
    @(posedge mclk);
    rstn <= 1'b1;
    wait_idle;
    chk("rst_busy", 1, busy_len >= 200 && busy_len <= 202);
    ram(7'h7F, 8'h20);
    s_write;
    s_entry;
    s_disp;
    s_shift;
    s_glyph;
    s_clear;
    s_func;
    wrap_up;
  end
endmodule : tb_lcd_instruction_decoder
